// File: hw/sga_addr_form.sv
`default_nettype none
`include "sga_map.svh"
// Behaviour
// RL1 - multibyte data stored low byte first
// RL2 - operand address is its low byte
// RL3 - paging works on 4 Kbyte pages
// RL4 - paging off: linear drives address pins
// RL5 - real mode: selector shl 4 plus offset
// RL6 - protected mode: descriptor base plus offset
// RL7 - fetches always code segment, no override
// RL8 - stack accesses use stack segment only
// RL9 - string store destination uses extra segment
// RL10 - data defaults data seg, frame/stack base stack
// RL11 - override prefix picks any of six
// RL12 - segments overlap freely, up to 4 GB
// RL13 - 64 Kbyte I/O space, any port width
// RL14 - I/O addresses bypass all translation
// RL15 - port from 8-bit immediate or register
// RL16 - port numbers zero extended upward
// RL17 - memory/io select low for I/O
// RL18 - system avoids ports F8h to FFh
// RL19 - real mode offset over FFFFh faults
// RL20 - linear sum wraps modulo 2^32
module sga_addr_form
  import sga_pkg::*;
#(
  parameter int PAGE_BITS = `SGA_PAGE_BITS
) (
  input  wire logic        i_clk,         // 50 MHz clock
  input  wire logic        i_rst,         // sync reset, active high
  input  wire logic        i_prot_mode,   // 1 = protected translation
  input  wire logic        i_paging_en,   // 1 = page translation on
  input  wire logic [19:0] i_page_frame,  // frame for current linear page
  input  wire logic        i_seg_wr,      // load a segment entry
  input  wire sga_seg_e    i_seg_wsel,    // entry to load
  input  wire logic [15:0] i_seg_sel,     // selector value
  input  wire logic [31:0] i_seg_base,    // descriptor linear base
  input  wire logic        i_req_valid,   // request strobe
  input  wire sga_req_s    i_req,         // request contents
  output sga_bus_s         o_bus,         // bus address, lanes, data
  output logic             o_bus_valid,   // bus cycle strobe
  output logic             o_gp_fault,    // general protection fault pulse
  output logic             o_busy         // request in progress
);
  typedef enum logic [1:0] {
    SGA_ST_IDLE = 2'h0,
    SGA_ST_LOOK = 2'h1,
    SGA_ST_FORM = 2'h2
  } sga_state_e;

  sga_state_e  state;
  sga_state_e  next_state;
  sga_req_s    req;
  sga_req_s    next_req;
  sga_seg_e    seg;
  sga_seg_e    next_seg;
  sga_bus_s    next_bus;
  logic        next_bus_valid;
  logic        next_gp_fault;
  logic        next_busy;
  logic [15:0] rd_sel;
  logic [31:0] rd_base;
  logic [31:0] lin;
  logic [31:0] phys;
  logic [15:0] port;

  // default segment choice per reference kind
  function automatic sga_seg_e pick_seg(input sga_req_s r);
    sga_seg_e s;
    s = SGA_SEG_DS;
    unique case (r.kind)
      SGA_REF_FETCH:  s = SGA_SEG_CS;                 // [RL7]
      SGA_REF_STACK:  s = SGA_SEG_SS;                 // [RL8]
      SGA_REF_STRDST: s = SGA_SEG_ES;                 // [RL9]
      SGA_REF_DATA: begin
        s = r.base_is_frame ? SGA_SEG_SS : SGA_SEG_DS; // [RL10]
        if (r.ovr_valid) begin
          s = r.ovr_seg;                              // [RL11]
        end
      end
      default:        s = SGA_SEG_DS;
    endcase
    return s;
  endfunction

  function automatic logic is_io(input sga_ref_e k);
    return (k == SGA_REF_IO_IMM) || (k == SGA_REF_IO_REG);
  endfunction

  // byte lane mask from size and low address bits, low byte at low address
  function automatic logic [3:0] lanes(input sga_size_e sz, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h1;
    unique case (sz)
      SGA_SZ_BYTE:  m = 4'h1;
      SGA_SZ_WORD:  m = 4'h3;
      SGA_SZ_DWORD: m = 4'hF;
      default:      m = 4'h1;
    endcase
    return 4'((m << a));                               // [RL1] [RL2]
  endfunction

  sga_seg_file u_seg (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_wr       (i_seg_wr),
    .i_wsel     (i_seg_wsel),
    .i_wsel_val (i_seg_sel),
    .i_wbase    (i_seg_base),
    .i_rsel     (seg),
    .o_sel      (rd_sel),
    .o_base     (rd_base)
  );

  // segment sizes up to 4 GB and free overlap: no limit check here [RL12]
  always_comb begin
    if (i_prot_mode) begin
      lin = rd_base + req.offset;                     // [RL6] [RL20]
    end else begin
      lin = (32'(rd_sel) << `SGA_REAL_SHIFT) + req.offset; // [RL5] [RL20]
    end
    if (i_paging_en) begin
      phys = {i_page_frame, lin[PAGE_BITS-1:0]};      // [RL3]
    end else begin
      phys = lin;                                     // [RL4]
    end
    if (req.kind == SGA_REF_IO_IMM) begin
      port = {8'h00, req.imm_port};                   // [RL15]
    end else begin
      port = req.port_number_reg;                     // [RL15]
    end
  end

  always_comb begin
    next_state     = state;
    next_req       = req;
    next_seg       = seg;
    next_bus       = o_bus;
    next_bus_valid = 1'b0;
    next_gp_fault  = 1'b0;
    next_busy      = o_busy;
    unique case (state)
      SGA_ST_IDLE: begin
        if (i_req_valid) begin
          next_req   = i_req;
          next_seg   = pick_seg(i_req);
          next_busy  = 1'b1;
          next_state = is_io(i_req.kind) ? SGA_ST_FORM : SGA_ST_LOOK;
        end
      end
      SGA_ST_LOOK: begin
        // segment file read data registered one cycle later
        next_state = SGA_ST_FORM;
      end
      SGA_ST_FORM: begin
        next_state = SGA_ST_IDLE;
        next_busy  = 1'b0;
        if (is_io(req.kind)) begin
          // I/O skips segment and page hardware entirely [RL14] [RL13]
          next_bus.addr          = {16'h0000, port};  // [RL16]
          next_bus.mem_io_n      = 1'b0;              // [RL17]
          next_bus.reserved_port = (port >= `SGA_RSV_PORT_LO) &&
                                   (port <= `SGA_RSV_PORT_HI); // [RL18]
          next_bus.byte_en       = lanes(req.size, port[1:0]);
          next_bus.data          = req.wdata << {port[1:0], 3'h0};
          next_bus_valid         = 1'b1;
        end else if (!i_prot_mode && (req.offset > `SGA_REAL_OFS_MAX)) begin
          next_gp_fault = 1'b1;                       // [RL19]
        end else begin
          next_bus.addr          = phys;
          next_bus.mem_io_n      = 1'b1;
          next_bus.reserved_port = 1'b0;
          next_bus.byte_en       = lanes(req.size, phys[1:0]);
          next_bus.data          = req.wdata << {phys[1:0], 3'h0}; // [RL1]
          next_bus_valid         = 1'b1;
        end
      end
      default: next_state = SGA_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state       <= SGA_ST_IDLE;
      req         <= '0;
      seg         <= SGA_SEG_DS;
      o_bus       <= '{addr: 32'h0, byte_en: 4'h0, data: 32'h0,
                       mem_io_n: 1'b1, reserved_port: 1'b0};
      o_bus_valid <= 1'b0;
      o_gp_fault  <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      state       <= next_state;
      req         <= next_req;
      seg         <= next_seg;
      o_bus       <= next_bus;
      o_bus_valid <= next_bus_valid;
      o_gp_fault  <= next_gp_fault;
      o_busy      <= next_busy;
    end
  end
endmodule
`default_nettype wire

// File: inc/sga_map.svh
`ifndef SGA_MAP_SVH
`define SGA_MAP_SVH
`define SGA_REAL_SHIFT      4
`define SGA_REAL_OFS_MAX    32'h0000FFFF
`define SGA_PAGE_BITS       12
`define SGA_IO_SPACE_BITS   16
`define SGA_IMM_PORT_BITS   8
`define SGA_RSV_PORT_LO     16'h00F8
`define SGA_RSV_PORT_HI     16'h00FF
`define SGA_SEG_CNT         6
`endif

// File: inc/sga_pkg.sv
`default_nettype none
package sga_pkg;
  typedef enum logic [2:0] {
    SGA_SEG_ES = 3'h0,
    SGA_SEG_CS = 3'h1,
    SGA_SEG_SS = 3'h2,
    SGA_SEG_DS = 3'h3,
    SGA_SEG_FS = 3'h4,
    SGA_SEG_GS = 3'h5
  } sga_seg_e;

  typedef enum logic [2:0] {
    SGA_REF_FETCH = 3'h0,
    SGA_REF_STACK = 3'h1,
    SGA_REF_STRDST = 3'h2,
    SGA_REF_DATA  = 3'h3,
    SGA_REF_IO_IMM = 3'h4,
    SGA_REF_IO_REG = 3'h5
  } sga_ref_e;

  typedef enum logic [1:0] {
    SGA_SZ_BYTE  = 2'h0,
    SGA_SZ_WORD  = 2'h1,
    SGA_SZ_DWORD = 2'h2
  } sga_size_e;

  // one address request from the execution core
  typedef struct packed {
    sga_ref_e   kind;
    sga_size_e  size;
    logic       base_is_frame;   // base is frame or stack pointer
    logic       ovr_valid;
    sga_seg_e   ovr_seg;
    logic [31:0] offset;
    logic [7:0]  imm_port;
    logic [15:0] port_number_reg;
    logic [31:0] wdata;
  } sga_req_s;

  // one bus cycle toward the outside
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] data;
    logic        mem_io_n;
    logic        reserved_port;
  } sga_bus_s;
endpackage
`default_nettype wire

// File: hw/sga_seg_file.sv
`default_nettype none
`include "sga_map.svh"
module sga_seg_file
  import sga_pkg::*;
#(
  parameter int SEG_CNT = `SGA_SEG_CNT
) (
  input  wire logic        i_clk,     // clock
  input  wire logic        i_rst,     // sync reset
  input  wire logic        i_wr,      // load one segment entry
  input  wire sga_seg_e    i_wsel,    // entry written
  input  wire logic [15:0] i_wsel_val,// selector value
  input  wire logic [31:0] i_wbase,   // descriptor linear base
  input  wire sga_seg_e    i_rsel,    // entry read
  output logic      [15:0] o_sel,     // registered selector
  output logic      [31:0] o_base     // registered base
);
  logic [15:0] sel_mem  [SEG_CNT];
  logic [31:0] base_mem [SEG_CNT];
  logic [15:0] next_sel;
  logic [31:0] next_base;

  always_comb begin
    next_sel  = sel_mem[i_rsel];
    next_base = base_mem[i_rsel];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sel  <= 16'h0000;
      o_base <= 32'h00000000;
    end else begin
      o_sel  <= next_sel;
      o_base <= next_base;
    end
  end

  // bases may overlap freely, nothing checks them
  genvar g;
  generate
    for (g = 0; g < SEG_CNT; g++) begin : g_ent
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          sel_mem[g]  <= 16'h0000;
          base_mem[g] <= 32'h00000000;
        end else if (i_wr && (int'(i_wsel) == g)) begin
          sel_mem[g]  <= i_wsel_val;
          base_mem[g] <= i_wbase;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: tb/sga_addr_form_assertions.sv
`default_nettype none
module sga_addr_form_chk
  import sga_pkg::*;
#(
  parameter int PAGE_BITS = 12
) (
  input wire logic        i_clk,        // clock
  input wire logic        i_rst,        // reset
  input wire logic        i_prot_mode,  // mode
  input wire logic        i_paging_en,  // paging
  input wire logic [19:0] i_page_frame, // frame
  input wire logic        i_req_valid,  // strobe
  input wire sga_req_s    i_req,        // request
  input wire sga_bus_s    o_bus,        // result
  input wire logic        o_bus_valid,  // valid
  input wire logic        o_gp_fault,   // fault
  input wire logic        o_busy        // busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic tk, io, ok, dw;
  assign tk = i_req_valid && !o_busy;
  assign io = i_req.kind inside {SGA_REF_IO_IMM, SGA_REF_IO_REG};
  // memory reference that must not fault
  assign ok = !io && (i_prot_mode || i_req.offset[31:16] == 16'h0000);
  assign dw = !i_prot_mode && i_req.size == SGA_SZ_DWORD && i_req.offset[1:0] == 2'h0;
  chk_io_timing: assert property (
    tk && io |-> ##1 (o_busy && !o_bus_valid) ##1 (o_bus_valid && !o_bus.mem_io_n && !o_busy))
    else $error("io");
  chk_imm_port: assert property (
    tk && i_req.kind == SGA_REF_IO_IMM |->
    ##2 o_bus.addr == {24'h000000, $past(i_req.imm_port, 2)}) else $error("imm port");
  chk_reg_port: assert property (
    tk && i_req.kind == SGA_REF_IO_REG |->
    ##2 o_bus.addr == {16'h0000, $past(i_req.port_number_reg, 2)}) else $error("reg port");
  chk_mem_timing: assert property (
    tk && ok |-> ##1 (o_busy && !o_bus_valid) ##1 (o_busy && !o_bus_valid)
    ##1 (o_bus_valid && o_bus.mem_io_n && !o_busy)) else $error("mem");
  chk_real_fault: assert property (
    tk && !io && !ok |-> ##3 (o_gp_fault && !o_bus_valid)) else $error("fault");
  chk_real_nibble: assert property (
    tk && ok && !i_prot_mode |-> ##3 o_bus.addr[3:0] == $past(i_req.offset[3:0], 3))
    else $error("real addr");
  chk_page_frame: assert property (
    tk && ok && i_paging_en |-> ##3 o_bus.addr[31:PAGE_BITS] == $past(i_page_frame, 3))
    else $error("page");
  chk_dword_lanes: assert property (
    tk && ok && dw |-> ##3 (o_bus.byte_en == 4'hF && o_bus.data == $past(i_req.wdata, 3)))
    else $error("lanes");
endmodule
bind sga_addr_form sga_addr_form_chk #(.PAGE_BITS(PAGE_BITS)) u_chk (
  .i_clk        (i_clk),
  .i_rst        (i_rst),
  .i_prot_mode  (i_prot_mode),
  .i_paging_en  (i_paging_en),
  .i_page_frame (i_page_frame),
  .i_req_valid  (i_req_valid),
  .i_req        (i_req),
  .o_bus        (o_bus),
  .o_bus_valid  (o_bus_valid),
  .o_gp_fault   (o_gp_fault),
  .o_busy       (o_busy)
);
`default_nettype wire

// File: tb/sga_bus_model.sv
`default_nettype none
module sga_bus_model
  import sga_pkg::*;
(
  input wire logic     i_clk,  // clock
  input wire sga_bus_s i_bus,  // cycle
  input wire logic     i_valid // strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  // io cycles reach no device here, reserved ports least of all
  always_ff @(posedge i_clk) begin
    if (i_valid && i_bus.mem_io_n) begin // select line splits the spaces
      for (int l = 0; l < 4; l++) begin
        if (i_bus.byte_en[l]) begin
          mem[{i_bus.addr[7:2], 2'(l)}] <= i_bus.data[8*l+:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top
  import sga_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, prot, pg, swr, rv, bv, gf, busy;
  logic [19:0] frame;
  logic [15:0] wsl;
  logic [31:0] wbase;
  sga_seg_e    wsel;
  sga_req_s    rq;
  sga_bus_s    bus;
  int          errors, cmp_count;
  sga_addr_form u_dut (.i_clk(clk), .i_rst(rst), .i_prot_mode(prot), .i_paging_en(pg),
    .i_page_frame(frame), .i_seg_wr(swr), .i_seg_wsel(wsel), .i_seg_sel(wsl),
    .i_seg_base(wbase), .i_req_valid(rv), .i_req(rq), .o_bus(bus), .o_bus_valid(bv),
    .o_gp_fault(gf), .o_busy(busy));
  sga_bus_model u_mdl (.i_clk(clk), .i_bus(bus), .i_valid(bv));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] ex, logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // returns in the cycle where the result stands
  task automatic go(sga_ref_e k, sga_size_e z, logic f, logic v, sga_seg_e s, logic [31:0] o);
    int n;
    rq = '{k, z, f, v, s, o, 8'hF8, 16'hFFFF, 32'h44332211};
    rv = 1'b1;
    @(negedge clk);
    rv = 1'b0;
    for (n = 0; n < 8 && bv !== 1'b1 && gf !== 1'b1; n++) @(negedge clk);
    if (n == 8) begin
      errors++;
      $display("ERROR result expected pulse seen none");
      wrap_up();
    end
  endtask
  task automatic rs(sga_ref_e k, logic f, logic v, sga_seg_e s, int e);
    go(k, SGA_SZ_BYTE, f, v, s, 32'h00000123);
    check("seg_addr", 32'h00010123 + 32'h00010000 * 32'(e), bus.addr);
  endtask
  task automatic t_le();
    go(SGA_REF_DATA, SGA_SZ_DWORD, 1'b0, 1'b0, SGA_SEG_DS, 32'h00000008);
    go(SGA_REF_DATA, SGA_SZ_WORD, 1'b0, 1'b0, SGA_SEG_DS, 32'h00000012);
    check("lanes", 32'h0000000C, {28'h0000000, bus.byte_en});
    for (int i = 0; i < 4; i++) begin
      check("byte", 32'h11 * (i + 1), {24'h000000, u_mdl.mem[8 + i]});
    end
  endtask
  task automatic t_sel();
    swr = 1'b1;
    wbase = 32'hFFFFFFF0;
    for (int i = 0; i < 6; i++) begin
      wsel = sga_seg_e'(3'(i));
      wsl = 16'(16'h1000 * (i + 1));
      @(negedge clk);
    end
    swr = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rs(SGA_REF_DATA, 1'b0, 1'b1, sga_seg_e'(3'(i)), i);
    end
    rs(SGA_REF_FETCH, 1'b0, 1'b1, SGA_SEG_GS, 1);
    rs(SGA_REF_STACK, 1'b0, 1'b1, SGA_SEG_DS, 2);
    rs(SGA_REF_STRDST, 1'b0, 1'b1, SGA_SEG_DS, 0);
    rs(SGA_REF_DATA, 1'b1, 1'b0, SGA_SEG_ES, 2);
    rs(SGA_REF_DATA, 1'b0, 1'b0, SGA_SEG_ES, 3);
  endtask
  task automatic t_prot();
    prot = 1'b1;
    go(SGA_REF_DATA, SGA_SZ_BYTE, 1'b0, 1'b0, SGA_SEG_ES, 32'h00000020);
    check("wrap", 32'h00000010, bus.addr);
    go(SGA_REF_DATA, SGA_SZ_BYTE, 1'b0, 1'b0, SGA_SEG_ES, 32'hF0000000);
    check("big", 32'hEFFFFFF0, bus.addr);
    prot = 1'b0;
    go(SGA_REF_STACK, SGA_SZ_BYTE, 1'b0, 1'b0, SGA_SEG_ES, 32'h00010000);
    check("fault", 32'h00000001, {31'h00000000, gf & ~bv});
  endtask
  task automatic t_io();
    pg = 1'b1;
    frame = 20'hABCDE;
    go(SGA_REF_IO_IMM, SGA_SZ_BYTE, 1'b0, 1'b0, SGA_SEG_DS, 32'h00000000);
    check("io_imm", 32'h000000F8, bus.addr);
    check("io_sel", 32'h00000000, {31'h00000000, bus.mem_io_n});
    check("io_rsv", 32'h00000001, {31'h00000000, bus.reserved_port});
    check("io_lanes", 32'h00000001, {28'h0000000, bus.byte_en});
    go(SGA_REF_IO_REG, SGA_SZ_WORD, 1'b0, 1'b0, SGA_SEG_DS, 32'h00000000);
    check("io_reg", 32'h0000FFFF, bus.addr);
    check("io_rsv", 32'h00000000, {31'h00000000, bus.reserved_port});
    go(SGA_REF_DATA, SGA_SZ_BYTE, 1'b0, 1'b0, SGA_SEG_DS, 32'h00000456);
    check("paged", 32'hABCDE456, bus.addr);
    check("mem_sel", 32'h00000001, {31'h00000000, bus.mem_io_n});
  endtask
  initial begin
    {rst, prot, pg, swr, rv} = 5'h10;
    {frame, wsl, wbase} = 68'h0;
    wsel = SGA_SEG_ES;
    rq = '0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_le();
    t_sel();
    t_prot();
    t_io();
    wrap_up();
  end
endmodule
`default_nettype wire
